// ==== fitp_consts.vh ====
// Constants for the flag, interrupt-request and timer-expired pin block.
// Assumes a 32-bit APB slave with 12-bit byte addresses.
`ifndef FITP_CONSTS_VH
`define FITP_CONSTS_VH

// Register byte offsets
`define FITP_OFF_FLAG_DIR 12'h000
`define FITP_OFF_FLAG_OUT 12'h004
`define FITP_OFF_FLAG_IN 12'h008
`define FITP_OFF_IRQ_EN 12'h00C
`define FITP_OFF_IRQ_MODE 12'h010
`define FITP_OFF_INT_STAT 12'h014
`define FITP_OFF_INT_MASK 12'h018
`define FITP_OFF_STRAP 12'h01C
`define FITP_OFF_FLAG_SET 12'h020
`define FITP_OFF_FLAG_CLR 12'h024

// Decoded register selects
`define FITP_SEL_NONE 4'h0
`define FITP_SEL_FLAG_DIR 4'h1
`define FITP_SEL_FLAG_OUT 4'h2
`define FITP_SEL_FLAG_IN 4'h3
`define FITP_SEL_IRQ_EN 4'h4
`define FITP_SEL_IRQ_MODE 4'h5
`define FITP_SEL_INT_STAT 4'h6
`define FITP_SEL_INT_MASK 4'h7
`define FITP_SEL_STRAP 4'h8
`define FITP_SEL_FLAG_SET 4'h9
`define FITP_SEL_FLAG_CLR 4'hA

// Reset values and the boot request-enable value
`define FITP_RST_FLAG_DIR 4'h0
`define FITP_RST_FLAG_OUT 4'h0
`define FITP_RST_IRQ_EN 4'h0
`define FITP_RST_IRQ_MODE 4'h0
`define FITP_RST_INT 5'h00
`define FITP_IRQ_ALL_ON 4'hF

// Field positions
`define FITP_STAT_TMR_BIT 4
`define FITP_STRAP_TMR_BIT 0
`define FITP_STRAP_BOOT_BIT 1
`define FITP_STRAP_DONE_BIT 2

// Cycles after reset release before the strap is caught
`define FITP_STRAP_SETTLE 2'h2

`endif

// ==== fitp_sync.v ====
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes one clock; the first stage is read only by the second.
`timescale 1ns/1ps
module fitp_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Asynchronous input and its synchronised copy
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_q
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule

// ==== fitp_irq_det.v ====
// Edge or level detector for one active-low interrupt request line.
// Assumes the line is already synchronised to pclk.
`timescale 1ns/1ps
module fitp_irq_det (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Synchronised line and its settings
  input wire line_n,
  input wire edge_mode,
  input wire enable,
  // Request toward the interrupt controller
  output reg req_q
);
  reg prev_n_q;
  wire fall;

  // Idle level is high, so no false edge after reset
  assign fall = prev_n_q & ~line_n;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_n_q <= 1'b1;
      req_q <= 1'b0;
    end else begin
      prev_n_q <= line_n;
      if (edge_mode) begin
        req_q <= enable & fall;
      end else begin
        req_q <= enable & ~line_n;
      end
    end
  end
endmodule

// ==== fitp_top.v ====
// Flag pins, external interrupt request lines and timer-expired pin
// with an APB register file and one level interrupt output.
// Assumes pclk at 20 MHz, timer 0 and the vector table on the same clock.
//
// Functional notes
// (RULE1) Each flag pin has its own direction bit, independent of the other pins.
// (RULE2) After reset every flag pin is an input with its driver off until software changes it.
// (RULE3) The sensed level of each flag pin is given to the sequencer as a testable condition.
// (RULE4) An asserted and enabled request line raises its interrupt toward the controller.
// (RULE5) Each request line has its own choice of edge or level detection.
// (RULE6) Request lines stay disabled after reset unless the boot strap and ready vectors enable them.
// (RULE7) Each timer 0 expiry gives one pulse on the timer-expired pin; the code drops expiries that come before the strap is caught.
// (RULE8) During reset the timer-expired pin is a strap set by the board and sampled by the device.
// (RULE9) Flag and request inputs pass two flops before use, and requests are active low.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "fitp_consts.vh"
module fitp_top #(
  parameter NFLAG = 4,
  parameter NIRQ = 4,
  parameter AW = 12
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // General flag pins
  input wire [NFLAG-1:0] general_flag_pins_i,
  output reg [NFLAG-1:0] general_flag_pins_o,
  output reg [NFLAG-1:0] general_flag_pins_oe_n,
  // Flag conditions toward the sequencer
  output reg [NFLAG-1:0] flag_cond_q,
  // External interrupt request lines, active low
  input wire [NIRQ-1:0] external_interrupt_lines_n,
  output wire [NIRQ-1:0] irq_req,
  // Boot strap and vector readiness
  input wire irq_boot_strap,
  input wire vectors_ready,
  // Timer 0 expiry and timer-expired pin
  input wire timer0_expire,
  input wire timer_expired_out_i,
  output reg timer_expired_out_o,
  output reg timer_expired_out_oe_n,
  // Interrupt output
  output wire int_out
);
  localparam NST = NIRQ + 1;

  // Address decode, shared by read and write paths
  function [3:0] reg_sel;
    input [AW-1:0] addr;
    begin
      case (addr)
        `FITP_OFF_FLAG_DIR: reg_sel = `FITP_SEL_FLAG_DIR;
        `FITP_OFF_FLAG_OUT: reg_sel = `FITP_SEL_FLAG_OUT;
        `FITP_OFF_FLAG_IN: reg_sel = `FITP_SEL_FLAG_IN;
        `FITP_OFF_IRQ_EN: reg_sel = `FITP_SEL_IRQ_EN;
        `FITP_OFF_IRQ_MODE: reg_sel = `FITP_SEL_IRQ_MODE;
        `FITP_OFF_INT_STAT: reg_sel = `FITP_SEL_INT_STAT;
        `FITP_OFF_INT_MASK: reg_sel = `FITP_SEL_INT_MASK;
        `FITP_OFF_STRAP: reg_sel = `FITP_SEL_STRAP;
        `FITP_OFF_FLAG_SET: reg_sel = `FITP_SEL_FLAG_SET;
        `FITP_OFF_FLAG_CLR: reg_sel = `FITP_SEL_FLAG_CLR;
        default: reg_sel = `FITP_SEL_NONE;
      endcase
    end
  endfunction

  // Registers
  reg [NFLAG-1:0] flag_dir_q;
  reg [NFLAG-1:0] flag_out_q;
  reg [NIRQ-1:0] irq_en_q;
  reg [NIRQ-1:0] irq_mode_q;
  reg [NST-1:0] int_stat_q;
  reg [NST-1:0] int_stat_d;
  reg [NST-1:0] int_mask_q;
  reg [1:0] strap_cnt_q;
  reg strap_done_q;
  reg strap_tmr_q;
  reg strap_boot_q;
  reg boot_arm_q;

  // Synchronised pins
  wire [NFLAG-1:0] flag_s;
  wire [NIRQ-1:0] irq_s_n;
  wire [1:0] strap_s;

  // Bus strobes
  wire setup;
  wire wr_en;
  wire [3:0] wr_sel;
  wire [3:0] rd_sel;
  wire [NST-1:0] events;
  // Decoded strobes and events
  wire irq_en_wr;
  wire irq_mode_wr;
  wire stat_wr;
  wire mask_wr;
  wire strap_catch;
  wire boot_fire;
  wire tmr_evt;

  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign wr_sel = reg_sel(paddr);
  assign rd_sel = reg_sel(paddr);

  // Write strobes per register, decoded once
  assign irq_en_wr = wr_en & (wr_sel == `FITP_SEL_IRQ_EN);
  assign irq_mode_wr = wr_en & (wr_sel == `FITP_SEL_IRQ_MODE);
  assign stat_wr = wr_en & (wr_sel == `FITP_SEL_INT_STAT);
  assign mask_wr = wr_en & (wr_sel == `FITP_SEL_INT_MASK);

  // Strap is caught once, after the chain has had time to settle
  assign strap_catch = ~strap_done_q & (strap_cnt_q == `FITP_STRAP_SETTLE);
  // Boot enable waits for the vectors, so no request finds an empty slot
  assign boot_fire = boot_arm_q & vectors_ready;
  // Expiries before the strap is caught are dropped to keep the pin free
  assign tmr_evt = timer0_expire & strap_done_q;

  fitp_sync #(
    .WIDTH(NFLAG),
    .RST_VAL({NFLAG{1'b0}})
  ) u_flag_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(general_flag_pins_i), // RULE9
    .sync_q(flag_s)
  );

  // Request lines rest high, so the chain resets high
  fitp_sync #(
    .WIDTH(NIRQ),
    .RST_VAL({NIRQ{1'b1}})
  ) u_irq_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(external_interrupt_lines_n), // RULE9
    .sync_q(irq_s_n)
  );

  fitp_sync #(
    .WIDTH(2),
    .RST_VAL(2'h0)
  ) u_strap_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({irq_boot_strap, timer_expired_out_i}),
    .sync_q(strap_s)
  );

  // One detector per request line
  genvar gi;
  generate
    for (gi = 0; gi < NIRQ; gi = gi + 1) begin : g_irq
      fitp_irq_det u_det (
        .pclk(pclk),
        .presetn(presetn),
        .line_n(irq_s_n[gi]), // RULE9
        .edge_mode(irq_mode_q[gi]), // RULE5
        .enable(irq_en_q[gi]),
        .req_q(irq_req[gi]) // RULE4
      );
    end
  endgenerate

  // Flag pins: direction and drive
  // Set and clear offsets spare software a read-modify-write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_dir_q <= `FITP_RST_FLAG_DIR; // RULE2
      flag_out_q <= `FITP_RST_FLAG_OUT;
    end else if (wr_en) begin
      case (wr_sel)
        `FITP_SEL_FLAG_DIR: begin
          flag_dir_q <= pwdata[NFLAG-1:0]; // RULE1
        end
        `FITP_SEL_FLAG_OUT: begin
          flag_out_q <= pwdata[NFLAG-1:0];
        end
        `FITP_SEL_FLAG_SET: begin
          flag_out_q <= flag_out_q | pwdata[NFLAG-1:0];
        end
        `FITP_SEL_FLAG_CLR: begin
          flag_out_q <= flag_out_q & ~pwdata[NFLAG-1:0];
        end
        default: begin
          flag_out_q <= flag_out_q;
        end
      endcase
    end
  end

  // Pin drivers come from flops to avoid glitches on the board
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_flag_pins_o <= {NFLAG{1'b0}};
      general_flag_pins_oe_n <= {NFLAG{1'b1}}; // RULE2
    end else begin
      general_flag_pins_o <= flag_out_q;
      general_flag_pins_oe_n <= ~flag_dir_q; // RULE1
    end
  end

  // Condition bits read the pin, so outputs read back their own drive
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_cond_q <= {NFLAG{1'b0}};
    end else begin
      flag_cond_q <= flag_s; // RULE3
    end
  end

  // Strap capture: pin held by the board, caught once the chain settles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_tmr_q <= 1'b0;
      strap_boot_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == `FITP_STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
        strap_tmr_q <= strap_s[0]; // RULE8
        strap_boot_q <= strap_s[1]; // RULE6
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  // Boot arm: set by the strap, dropped once used or when software takes over
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_arm_q <= 1'b0;
    end else if (strap_catch) begin
      boot_arm_q <= strap_s[1]; // RULE6
    end else if (irq_en_wr | boot_fire) begin
      boot_arm_q <= 1'b0;
    end
  end

  // Request enables: off after reset; a software write beats the boot enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= `FITP_RST_IRQ_EN; // RULE6
      irq_mode_q <= `FITP_RST_IRQ_MODE;
    end else begin
      if (irq_en_wr) begin
        irq_en_q <= pwdata[NIRQ-1:0];
      end else if (boot_fire) begin
        irq_en_q <= `FITP_IRQ_ALL_ON; // RULE6
      end
      if (irq_mode_wr) begin
        irq_mode_q <= pwdata[NIRQ-1:0]; // RULE5
      end
    end
  end

  // Timer-expired pin: released during reset and until the strap is caught
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_expired_out_o <= 1'b0;
      timer_expired_out_oe_n <= 1'b1; // RULE8
    end else begin
      timer_expired_out_oe_n <= ~strap_done_q; // RULE8
      timer_expired_out_o <= tmr_evt; // RULE7
    end
  end

  // Sticky status: a new event wins over a write-one clear
  assign events = {tmr_evt, irq_req};

  always @* begin
    int_stat_d = int_stat_q;
    if (stat_wr) begin
      int_stat_d = int_stat_d & ~pwdata[NST-1:0];
    end
    int_stat_d = int_stat_d | events; // RULE4
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= `FITP_RST_INT;
      int_mask_q <= `FITP_RST_INT;
    end else begin
      int_stat_q <= int_stat_d;
      if (mask_wr) begin
        int_mask_q <= pwdata[NST-1:0];
      end
    end
  end

  assign int_out = |(int_stat_q & int_mask_q);

  // Read data is loaded in setup, so the access phase needs no wait
  // Unmapped offsets read zero with an error; writes there are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= (rd_sel == `FITP_SEL_NONE);
      prdata <= 32'h00000000;
      case (rd_sel)
        `FITP_SEL_FLAG_DIR: begin
          prdata[NFLAG-1:0] <= flag_dir_q;
        end
        `FITP_SEL_FLAG_OUT: begin
          prdata[NFLAG-1:0] <= flag_out_q;
        end
        `FITP_SEL_FLAG_IN: begin
          prdata[NFLAG-1:0] <= flag_s; // RULE3
        end
        `FITP_SEL_IRQ_EN: begin
          prdata[NIRQ-1:0] <= irq_en_q;
        end
        `FITP_SEL_IRQ_MODE: begin
          prdata[NIRQ-1:0] <= irq_mode_q;
        end
        `FITP_SEL_INT_STAT: begin
          prdata[NST-1:0] <= int_stat_q;
        end
        `FITP_SEL_INT_MASK: begin
          prdata[NST-1:0] <= int_mask_q;
        end
        `FITP_SEL_STRAP: begin
          prdata[`FITP_STRAP_TMR_BIT] <= strap_tmr_q;
          prdata[`FITP_STRAP_BOOT_BIT] <= strap_boot_q;
          prdata[`FITP_STRAP_DONE_BIT] <= strap_done_q;
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end
endmodule

// ==== fitp_top_sva.sv ====
// Checker for the flag, request-line and timer-expired pin block.
// Assumes only the top module's ports; bound at the foot of this file.
`timescale 1ns/1ps
module fitp_top_sva #(
  parameter NFLAG = 4,
  parameter NIRQ = 4,
  parameter AW = 12
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  // Pins, conditions and requests
  input wire [NFLAG-1:0] general_flag_pins_i,
  input wire [NFLAG-1:0] general_flag_pins_oe_n,
  input wire [NFLAG-1:0] flag_cond_q,
  input wire [NIRQ-1:0] external_interrupt_lines_n,
  input wire [NIRQ-1:0] irq_req,
  input wire timer0_expire,
  input wire timer_expired_out_o,
  input wire timer_expired_out_oe_n,
  input wire int_out
);
  // Cycles since reset; pipelines still hold reset values before 7
  reg [2:0] up_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence s_strap_wait;
    timer_expired_out_oe_n [*4] ##1 !timer_expired_out_oe_n;
  endsequence
  oe_rst_a: assert property ($rose(presetn) |-> general_flag_pins_oe_n == '1)
    else $error("flag driver on after reset");
  dir_oe_a: assert property (s_wr(12'h000) |-> ##2 (~general_flag_pins_oe_n) == $past(pwdata[NFLAG-1:0], 2))
    else $error("flag enables do not follow direction write");
  flag_cond_a: assert property (up_q == 3'h7 |-> flag_cond_q == $past(general_flag_pins_i, 3))
    else $error("flag condition not pin level three cycles back");
  irq_src_a: assert property (up_q == 3'h7 |-> (irq_req & $past(external_interrupt_lines_n, 3)) == '0)
    else $error("request without low line three cycles back");
  int_cause_a: assert property ($rose(int_out) |-> $past(irq_req) != '0 || $past(timer0_expire) || $past(psel))
    else $error("interrupt output rose without cause");
  strap_hold_a: assert property ($rose(presetn) |-> s_strap_wait)
    else $error("timer pin driven during strap window");
  tmr_src_a: assert property (timer_expired_out_o |-> $past(timer0_expire))
    else $error("timer pulse without expiry");
  tmr_pulse_a: assert property (timer0_expire && up_q == 3'h7 |=> timer_expired_out_o)
    else $error("expiry gave no timer pulse");
endmodule
bind fitp_top fitp_top_sva #(.NFLAG(NFLAG), .NIRQ(NIRQ), .AW(AW)) u_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .general_flag_pins_i, .general_flag_pins_oe_n, .flag_cond_q,
  .external_interrupt_lines_n, .irq_req, .timer0_expire, .timer_expired_out_o, .timer_expired_out_oe_n, .int_out);

// ==== fitp_pins.sv ====
// Board model: pulled-up flag and request lines, external drivers, strap.
// Assumes the design's enables are low while it drives a pin.
`timescale 1ns/1ps
module fitp_pins (
  // Design drive side
  input wire [3:0] flag_o,
  input wire [3:0] flag_oe_n,
  input wire tmr_o,
  input wire tmr_oe_n,
  // Board controls
  input wire [3:0] ext_en,
  input wire [3:0] ext_val,
  input wire [3:0] irq_low,
  input wire strap,
  // Resolved pin levels
  output wire [3:0] flag_pin,
  output wire [3:0] irq_n,
  output wire tmr_pin
);
  // Undriven flag pins float to the pull-up
  assign flag_pin = (~flag_oe_n & flag_o) | (flag_oe_n & ext_en & ext_val) | (flag_oe_n & ~ext_en);
  assign irq_n = ~irq_low;
  // Strap level shows until the device drives
  assign tmr_pin = tmr_oe_n ? strap : tmr_o;
endmodule

// ==== tb_top.sv ====
// Testbench for the flag, request-line and timer-expired pin block.
// Assumes fitp_top, the board model fitp_pins and the bound checker.
`timescale 1ns/1ps
`include "fitp_consts.vh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se, strap = 1, boot = 0, vrdy = 0, t0 = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [3:0] ext_en = 0, ext_val = 0, irq_low = 0;
  wire [31:0] prdata;
  wire pready, pslverr, int_out, tmr_o, tmr_oe_n, tmr_pin;
  wire [3:0] fo, foe_n, fcond, flag_pin, irq_n, irq_req;
  int errors = 0, n_compared = 0;
  initial forever #25 pclk = ~pclk;
  fitp_top u_fitp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_flag_pins_i(flag_pin), .general_flag_pins_o(fo), .general_flag_pins_oe_n(foe_n),
    .flag_cond_q(fcond), .external_interrupt_lines_n(irq_n), .irq_req(irq_req), .irq_boot_strap(boot),
    .vectors_ready(vrdy), .timer0_expire(t0), .timer_expired_out_i(tmr_pin), .timer_expired_out_o(tmr_o),
    .timer_expired_out_oe_n(tmr_oe_n), .int_out(int_out));
  fitp_pins u_fitp_pins (.flag_o(fo), .flag_oe_n(foe_n), .tmr_o(tmr_o), .tmr_oe_n(tmr_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .irq_low(irq_low), .strap(strap), .flag_pin(flag_pin), .irq_n(irq_n), .tmr_pin(tmr_pin));
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Drives land on the edge by NBA; reads here see what stood before the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      errors++;
      final_report();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rst;
    presetn <= 1'h0;
    cyc(4);
    presetn <= 1'h1;
    cyc(6);
  endtask
  initial begin
    rst();
    chk("flag_oe_n", foe_n, 4'hF);
    chk("tmr_oe_n", tmr_oe_n, 1'h0);
    apb(1'h0, `FITP_OFF_STRAP, 32'h0);
    chk("strap", rd, 32'h5);
    irq_low <= 4'hF;
    cyc(6);
    chk("irq_off", irq_req, 4'h0);
    irq_low <= 4'h0;
    apb(1'h0, 12'h030, 32'h0);
    chk("unmapped", {se, rd[30:0]}, 32'h80000000);
    ext_en <= 4'hA;
    ext_val <= 4'h8;
    apb(1'h1, `FITP_OFF_FLAG_DIR, 32'h5);
    apb(1'h1, `FITP_OFF_FLAG_OUT, 32'hF);
    cyc(4);
    chk("flag_oe_n", foe_n, 4'hA);
    chk("flag_cond", fcond, 4'hD);
    apb(1'h0, `FITP_OFF_FLAG_IN, 32'h0);
    chk("flag_in", rd, 32'hD);
    apb(1'h1, `FITP_OFF_FLAG_CLR, 32'h4);
    cyc(4);
    chk("flag_cond", fcond, 4'h9);
    apb(1'h1, `FITP_OFF_FLAG_SET, 32'h4);
    apb(1'h0, `FITP_OFF_FLAG_OUT, 32'h0);
    chk("flag_set", rd, 32'hF);
    apb(1'h1, `FITP_OFF_IRQ_EN, 32'hF);
    apb(1'h1, `FITP_OFF_INT_MASK, 32'h1F);
    apb(1'h1, `FITP_OFF_IRQ_MODE, 32'hA);
    for (int i = 0; i < 4; i++) begin
      irq_low <= 4'h1 << i;
      cyc(3);
      chk("irq_early", irq_req, 4'h0);
      cyc(1);
      chk("irq_req", irq_req, 4'h1 << i);
      cyc(1);
      chk("irq_hold", irq_req, i[0] ? 4'h0 : 4'h1 << i);
      chk("int_out", int_out, 1'h1);
      irq_low <= 4'h0;
      cyc(4);
      apb(1'h1, `FITP_OFF_INT_STAT, 32'h1 << i);
      apb(1'h0, `FITP_OFF_INT_STAT, 32'h0);
      chk("stat_clr", {int_out, rd[30:0]}, 32'h0);
    end
    t0 <= 1'h1;
    cyc(1);
    t0 <= 1'h0;
    cyc(1);
    chk("tmr_pin", tmr_pin, 1'h1);
    cyc(1);
    chk("tmr_end", tmr_o, 1'h0);
    apb(1'h0, `FITP_OFF_INT_STAT, 32'h0);
    chk("tmr_stat", rd, 32'h10);
    strap <= 1'h0;
    boot <= 1'h1;
    rst();
    apb(1'h0, `FITP_OFF_IRQ_EN, 32'h0);
    chk("boot_wait", rd, 32'h0);
    vrdy <= 1'h1;
    cyc(2);
    apb(1'h0, `FITP_OFF_IRQ_EN, 32'h0);
    chk("boot_en", rd, 32'hF);
    apb(1'h0, `FITP_OFF_STRAP, 32'h0);
    chk("strap_boot", rd, 32'h6);
    final_report();
  end
endmodule
